//--- hw/owd_phy.v
// Purpose: Physical layer of a single-pin half-duplex debug port.
// Assumes: Line pin is open drain, inputs synchronous to clk.
// Notes: Port clock is a fractional tick enable derived from clk.
`timescale 1ns/100ps
`include "owd_map.vh"
// Overview of operation
// - Frames are start low, eight data, even parity, two high stops.
// - Wrong parity or low stop bit raises an error.
// - Parity disable bit skips the parity check entirely.
// - Idle is simply the line held high.
// - Twelve low bit periods return the port to default state.
// - A synch is expected after a break and before new instructions.
// - An acknowledge frame is sent when a store gains bus access.
// - Measured baud serves receive and transmit; no writable baud.
// - Port clock starts at 4 MHz; the divider field or a break changes it.
// - Divider codes 1=16, 2=8, 3=4 MHz; code 0 reserved.
// - Fractional baud counting; receiver tolerates +4.76/-3.61 percent.
// - Break during receive is frame error, during send contention.
// - A break resets the divider select to the 4 MHz default.
// - Synch is an ordinary data frame with value 0x55.
// - A valid synch after disable enables the port.
// - After repeat, synch only before the first following instruction.
// - Sixteen-bit count of port clocks over the synch sets timing.
// - Hand-over to the access layer passes a registered boundary.
// - No synch start within 65536 port clocks disables the port.
// - Synch overflowing the counter or too short disables the port.
module owd_phy #(
  parameter TIMEOUT_CYC = `OWD_TIMEOUT_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire line_in,
  output reg line_out,
  output reg line_oe,
  output reg [7:0] rx_data,
  output reg rx_valid,
  output reg rx_err,
  input wire [7:0] tx_data,
  input wire tx_req,
  input wire ack_req,
  input wire synch_expect,
  output reg tx_busy,
  output reg synch_ok,
  output reg port_enabled
);

  // ==========================================================
  // States and derived constants
  localparam [2:0] ST_DIS = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_SYN = 3'h2;
  localparam [2:0] ST_SYNT = 3'h3;
  localparam [2:0] ST_IDLE = 3'h4;
  localparam [2:0] ST_RX = 3'h5;
  localparam [2:0] ST_TX = 3'h6;
  // Phase step per clk for each port clock rate, 16-bit fraction
  localparam [63:0] INC16_W = (`OWD_F16_HZ * 64'd65536) / `OWD_CLK_HZ;
  localparam [63:0] INC8_W = (`OWD_F8_HZ * 64'd65536) / `OWD_CLK_HZ;
  localparam [63:0] INC4_W = (`OWD_F4_HZ * 64'd65536) / `OWD_CLK_HZ;
  localparam [16:0] INC16 = INC16_W[16:0];
  localparam [16:0] INC8 = INC8_W[16:0];
  localparam [16:0] INC4 = INC4_W[16:0];
  localparam integer TOUT_I = TIMEOUT_CYC - 1;
  localparam [16:0] TOUT = TOUT_I[16:0];

  // ==========================================================
  // Helpers
  function even_par;
    input [7:0] d;
    begin
      even_par = ^d;
    end
  endfunction

  function [11:0] frame_of;
    input [7:0] d;
    begin
      frame_of = {2'b11, even_par(d), d, 1'b0};
    end
  endfunction

  // ==========================================================
  // State
  reg [2:0] state_reg;
  reg [15:0] phase_reg;
  reg [16:0] hacc_reg;
  reg [4:0] hcnt_reg;
  reg [15:0] baud_reg;
  reg [15:0] scnt_reg;
  reg [2:0] edges_reg;
  reg [16:0] tcnt_reg;
  reg [17:0] low_reg;
  reg [11:0] shf_reg;
  reg line_reg;
  reg need_sync_reg;
  reg parity_check_disable_reg;
  reg [1:0] div_reg;
  reg [4:1] sts_reg;
  reg tx_pend_reg;
  reg [7:0] tx_byte_reg;

  // ==========================================================
  // Port clock tick from the divider select
  reg [16:0] inc;
  always @*
  begin
    case (div_reg)
      `OWD_DIV_16M: inc = INC16;
      `OWD_DIV_8M: inc = INC8;
      default: inc = INC4;
    endcase
  end

  wire [16:0] ph_sum = {1'b0, phase_reg} + inc;
  wire tick = ph_sum[16];
  // Half-bit pulses: each tick adds 16 against the 8-bit count,
  // so fractions of a tick per bit carry over instead of drifting
  wire [16:0] h_sum = hacc_reg + 17'h00010;
  wire half = tick && (h_sum >= {1'b0, baud_reg});
  wire fall = line_reg && !line_in;
  wire [18:0] low2 = {low_reg, 1'b0};
  wire [18:0] brk_lim = {1'b0, baud_reg, 2'b00} - {3'b000, baud_reg};
  // Twelve bits are 1.5 times the eight-bit synch count
  wire brk = !line_in && (low2 >= brk_lim);
  wire [4:0] hnext = hcnt_reg + 5'h01;
  wire [3:0] bidx = hcnt_reg[4:1];

  // ==========================================================
  // Main sequencing
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_WAIT;
      phase_reg <= 16'h0000;
      hacc_reg <= 17'h00000;
      hcnt_reg <= 5'h00;
      baud_reg <= `OWD_BAUD_RST;
      scnt_reg <= 16'h0000;
      edges_reg <= 3'h0;
      tcnt_reg <= 17'h00000;
      low_reg <= 18'h00000;
      shf_reg <= 12'hFFF;
      line_reg <= 1'b1;
      need_sync_reg <= 1'b1;
      parity_check_disable_reg <= 1'b0;
      div_reg <= `OWD_DIV_4M;
      sts_reg <= 4'h0;
      tx_pend_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      reg_rdata <= 32'h00000000;
      line_out <= 1'b0;
      line_oe <= 1'b0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      tx_busy <= 1'b0;
      synch_ok <= 1'b0;
      port_enabled <= 1'b0;
    end
    else
    begin
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      synch_ok <= 1'b0;
      line_reg <= line_in;
      phase_reg <= ph_sum[15:0];
      if (half)
        hacc_reg <= h_sum - {1'b0, baud_reg};
      else if (tick)
        hacc_reg <= h_sum;
      if (line_in)
        low_reg <= 18'h00000;
      else if (tick && low_reg != 18'h3FFFF)
        low_reg <= low_reg + 18'h00001;
      // Register port; no baud register is writable
      if (reg_wr && reg_addr == `OWD_CTRL_OFS)
      begin
        parity_check_disable_reg <= reg_wdata[`OWD_CTRL_PARITY_CHECK_DISABLE];
        if (reg_wdata[`OWD_CTRL_DIV_HI:`OWD_CTRL_DIV_LO] != `OWD_DIV_RSVD)
          div_reg <= reg_wdata[`OWD_CTRL_DIV_HI:`OWD_CTRL_DIV_LO];
      end
      if (reg_wr && reg_addr == `OWD_STS_OFS)
        sts_reg <= sts_reg & ~reg_wdata[4:1];
      if (reg_rd)
      begin
        case (reg_addr)
          `OWD_CTRL_OFS: reg_rdata <= {29'h0, div_reg, parity_check_disable_reg};
          `OWD_STS_OFS: reg_rdata <= {27'h0, sts_reg, port_enabled};
          `OWD_BAUD_OFS: reg_rdata <= {16'h0, baud_reg};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
      else
        reg_rdata <= 32'h00000000;
      // Requests from the data link side are latched on their own
      // cycle, but a pulse that comes while one is pending or a frame is being sent is lost
      if ((ack_req || tx_req) && !tx_pend_reg && state_reg != ST_TX)
      begin
        tx_pend_reg <= 1'b1;
        tx_byte_reg <= ack_req ? `OWD_ACK_BYTE : tx_data;
      end
      if (synch_expect)
        need_sync_reg <= 1'b1;
      tx_busy <= tx_pend_reg || state_reg == ST_TX;
      case (state_reg)
        ST_DIS:
        begin
          port_enabled <= 1'b0;
          if (fall)
          begin
            state_reg <= ST_SYN;
            scnt_reg <= 16'h0000;
            edges_reg <= 3'h0;
          end
        end
        ST_WAIT:
        begin
          if (fall)
          begin
            state_reg <= ST_SYN;
            scnt_reg <= 16'h0000;
            edges_reg <= 3'h0;
          end
          else if (tick)
          begin
            if (tcnt_reg == TOUT)
              state_reg <= ST_DIS;
            else
              tcnt_reg <= tcnt_reg + 17'h00001;
          end
        end
        ST_SYN:
        begin
          // Start edge to the fourth later fall spans eight bits
          // A break here would otherwise leave the count hanging
          if (brk)
          begin
            div_reg <= `OWD_DIV_4M;
            need_sync_reg <= 1'b1;
            tx_pend_reg <= 1'b0;
            low_reg <= 18'h00000;
            state_reg <= ST_IDLE;
          end
          else if (fall && edges_reg == `OWD_SYNCH_EDGES - 3'h1)
          begin
            if (scnt_reg < `OWD_BAUD_MIN)
            begin
              sts_reg[`OWD_STS_SERR] <= 1'b1;
              state_reg <= ST_DIS;
            end
            else
            begin
              baud_reg <= scnt_reg;
              hacc_reg <= 17'h00000;
              hcnt_reg <= 5'h00;
              state_reg <= ST_SYNT;
            end
          end
          else
          begin
            if (fall)
              edges_reg <= edges_reg + 3'h1;
            if (tick)
            begin
              if (scnt_reg == 16'hFFFF)
              begin
                sts_reg[`OWD_STS_SERR] <= 1'b1;
                state_reg <= ST_DIS;
              end
              else
                scnt_reg <= scnt_reg + 16'h0001;
            end
          end
        end
        ST_SYNT:
        begin
          // Ride out the last data bit, parity and into the stops
          if (half)
          begin
            hcnt_reg <= hnext;
            if (hnext == `OWD_SYNCH_TAIL)
            begin
              state_reg <= ST_IDLE;
              need_sync_reg <= 1'b0;
              port_enabled <= 1'b1;
              synch_ok <= 1'b1;
            end
          end
        end
        ST_IDLE:
        begin
          if (brk)
          begin
            div_reg <= `OWD_DIV_4M;
            need_sync_reg <= 1'b1;
            tx_pend_reg <= 1'b0;
            low_reg <= 18'h00000;
          end
          else if (fall)
          begin
            hacc_reg <= 17'h00000;
            hcnt_reg <= 5'h00;
            edges_reg <= 3'h0;
            scnt_reg <= 16'h0000;
            state_reg <= need_sync_reg ? ST_SYN : ST_RX;
          end
          else if (tx_pend_reg && line_in)
          begin
            hacc_reg <= 17'h00000;
            hcnt_reg <= 5'h00;
            shf_reg <= frame_of(tx_byte_reg);
            tx_pend_reg <= 1'b0;
            line_oe <= 1'b1;
            state_reg <= ST_TX;
          end
        end
        ST_RX:
        begin
          if (half)
          begin
            hcnt_reg <= hnext;
            if (hcnt_reg[0] == 1'b0)
            begin
              // Sample at mid bit, shifting in LSB first
              shf_reg <= {line_in, shf_reg[11:1]};
              if (bidx == 4'h0 && line_in)
                state_reg <= ST_IDLE;
              else if (bidx >= 4'hA && !line_in)
              begin
                sts_reg[`OWD_STS_FERR] <= 1'b1;
                rx_err <= 1'b1;
                low_reg <= 18'h00000;
                state_reg <= ST_IDLE;
              end
              else if (bidx == 4'hB)
              begin
                state_reg <= ST_IDLE;
                rx_data <= shf_reg[9:2];
                if (!parity_check_disable_reg && even_par(shf_reg[9:2]) != shf_reg[10])
                begin
                  sts_reg[`OWD_STS_PERR] <= 1'b1;
                  rx_err <= 1'b1;
                end
                else
                  rx_valid <= 1'b1;
              end
            end
          end
        end
        ST_TX:
        begin
          if (half)
          begin
            hcnt_reg <= hnext;
            if (hcnt_reg[0] == 1'b1)
            begin
              // Open drain: drive only the low bits
              line_oe <= !shf_reg[1];
              shf_reg <= {1'b1, shf_reg[11:1]};
              if (hnext == `OWD_FRAME_HALVES)
              begin
                line_oe <= 1'b0;
                state_reg <= ST_IDLE;
              end
            end
            else if (shf_reg[0] && !line_in)
            begin
              // Released high yet read low: someone holds the line
              sts_reg[`OWD_STS_CERR] <= 1'b1;
              line_oe <= 1'b0;
              low_reg <= 18'h00000;
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

//--- hw/owd_map.vh
// Purpose: Constants for the one-wire debug port physical layer.
// Assumes: 40 MHz system clock, registers up to 16 bits wide in 32-bit data.
// Notes: Offsets are byte addresses on the plain register port.
`ifndef OWD_MAP_VH
`define OWD_MAP_VH
// ==========================================================
// Register map
`define OWD_CTRL_OFS 8'h00
`define OWD_STS_OFS 8'h04
`define OWD_BAUD_OFS 8'h08
// ==========================================================
// Control fields
`define OWD_CTRL_PARITY_CHECK_DISABLE 0
`define OWD_CTRL_DIV_LO 1
`define OWD_CTRL_DIV_HI 2
`define OWD_DIV_RSVD 2'h0
`define OWD_DIV_16M 2'h1
`define OWD_DIV_8M 2'h2
`define OWD_DIV_4M 2'h3
// ==========================================================
// Status fields
`define OWD_STS_EN 0
`define OWD_STS_PERR 1
`define OWD_STS_FERR 2
`define OWD_STS_CERR 3
`define OWD_STS_SERR 4
// ==========================================================
// Frame and timing
`define OWD_SYNCH_BYTE 8'h55
`define OWD_ACK_BYTE 8'h40
`define OWD_FRAME_HALVES 5'h18
`define OWD_SYNCH_EDGES 3'h4
`define OWD_SYNCH_TAIL 5'h07
`define OWD_BAUD_MIN 16'h0010
`define OWD_BAUD_RST 16'hFFFF
`define OWD_CLK_HZ 64'd40000000
`define OWD_F16_HZ 64'd16000000
`define OWD_F8_HZ 64'd8000000
`define OWD_F4_HZ 64'd4000000
`define OWD_TIMEOUT_CYC 65536
`endif

//--- tb/owd_phy_monitor.sv
// Purpose: Port checks for the debug port physical layer
// Assumes: Device bit periods of eight clk or more
// Notes: Bound into every owd_phy instance
`timescale 1ns/100ps
module owd_phy_monitor #(
  parameter TIMEOUT_CYC = 65536
) (
  input wire clk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire line_in,
  input wire line_out,
  input wire line_oe,
  input wire [7:0] rx_data,
  input wire rx_valid,
  input wire rx_err,
  input wire [7:0] tx_data,
  input wire tx_req,
  input wire ack_req,
  input wire synch_expect,
  input wire tx_busy,
  input wire synch_ok,
  input wire port_enabled
);
// ======================
// Assertions
default clocking mon_cb @(posedge clk);
endclocking
default disable iff (!rst_n);
a_rdata_quiet: assert property
  (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data leak");
a_open_drain: assert property
  (line_out == 1'b0) else $error("line driven high");
a_rx_exclusive: assert property
  (!(rx_valid && rx_err)) else $error("good and bad frame at once");
a_valid_pulse: assert property
  (rx_valid |=> !rx_valid) else $error("frame pulse too long");
a_synch_enables: assert property
  (synch_ok |=> port_enabled) else $error("synch did not enable");
a_busy_cause: assert property
  ($rose(tx_busy) |-> $past(ack_req || tx_req, 2)) else $error("busy unasked");
a_drive_in_tx: assert property
  (line_oe |-> tx_busy) else $error("line pulled outside send");
a_start_width: assert property
  ($rose(line_oe) |-> line_oe [*8]) else $error("start bit too short");
a_quiet_in_tx: assert property
  (line_oe |-> !rx_valid && !synch_ok) else $error("receive during send");
c_rx: cover property (rx_valid);
c_err: cover property (rx_err);
c_synch: cover property (synch_ok);
c_send: cover property ($rose(line_oe));
endmodule
bind owd_phy owd_phy_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mon (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .line_in(line_in), .line_out(line_out),
  .line_oe(line_oe), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_err(rx_err), .tx_data(tx_data), .tx_req(tx_req),
  .ack_req(ack_req), .synch_expect(synch_expect), .tx_busy(tx_busy),
  .synch_ok(synch_ok), .port_enabled(port_enabled));

//--- tb/owd_host.sv
// Purpose: Programmer-side model on the shared debug line
// Assumes: Line has a pull-up; model only ever pulls low
// Notes: Exact clk counts per bit, so no host baud error
`timescale 1ns/100ps
module owd_host (
  input wire clk,
  input wire line,
  output reg drive_low
);
initial drive_low = 1'b0;
task put_bit(input b, input integer bt);
  begin
    drive_low <= ~b;
    repeat (bt) @(posedge clk);
  end
endtask
// Host starts each exchange; bad parity or stop only on request
task send_frame(input [7:0] d, input bp, input bs, input integer bt);
  integer i;
  begin
    @(posedge clk);
    put_bit(1'b0, bt);
    for (i = 0; i < 8; i = i + 1)
      put_bit(d[i], bt);
    put_bit(^d ^ bp, bt);
    put_bit(~bs, bt);
    put_bit(1'b1, bt);
  end
endtask
// Shortened break; long enough for twelve bits at any divider
task send_break(input integer n);
  begin
    @(posedge clk);
    drive_low <= 1'b1;
    repeat (n) @(posedge clk);
    drive_low <= 1'b0;
    repeat (400) @(posedge clk);
  end
endtask
// Samples all twelve bits at mid bit, start bit in f[0]
task recv_frame(input integer bt, output [11:0] f);
  integer i;
  begin
    i = 0;
    while (line === 1'b1 && i < 9000)
    begin
      @(posedge clk);
      i = i + 1;
    end
    repeat (bt / 2) @(posedge clk);
    for (i = 0; i < 12; i = i + 1)
    begin
      f[i] = line;
      repeat (bt) @(posedge clk);
    end
  end
endtask
endmodule

//--- tb/test_one_wire_debug_uart_phy.sv
// Purpose: Self-checking bench for the debug port physical layer
// Assumes: Host bit period 200 clk, within the 4 MHz baud range
// Notes: Disable timeout shortened through TIMEOUT_CYC
`timescale 1ns/100ps
`include "owd_map.vh"
module test_one_wire_debug_uart_phy;
localparam integer BT = 200;
reg clk = 1'b0;
reg rst_n = 1'b0;
reg [7:0] reg_addr = 8'h00;
reg [31:0] reg_wdata = 32'h0;
reg reg_wr = 1'b0;
reg reg_rd = 1'b0;
reg [7:0] tx_data = 8'h00;
reg tx_req = 1'b0;
reg ack_req = 1'b0;
reg synch_expect = 1'b0;
wire [31:0] reg_rdata;
wire [7:0] rx_data;
wire line_out, line_oe, rx_valid, rx_err, tx_busy, synch_ok, port_enabled;
wire host_low;
wire line_w = ~host_low & ~(line_oe & ~line_out);
integer err_count = 0;
integer compares = 0;
integer n_ok = 0, n_err = 0, n_syn = 0, i;
reg [31:0] rd;
reg [11:0] fr;
reg [7:0] last_rx;
reg [10:0] rows [0:5];
always #12.5 clk = ~clk;
owd_phy #(.TIMEOUT_CYC(64)) DUT (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .line_in(line_w), .line_out(line_out), .line_oe(line_oe),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err),
  .tx_data(tx_data), .tx_req(tx_req), .ack_req(ack_req),
  .synch_expect(synch_expect), .tx_busy(tx_busy), .synch_ok(synch_ok),
  .port_enabled(port_enabled));
owd_host host (.clk(clk), .line(line_w), .drive_low(host_low));
// ======================
// Pulse counters, sampled away from the active edge
always @(negedge clk)
begin
  if (rx_valid === 1'b1) n_ok = n_ok + 1;
  if (rx_err === 1'b1) n_err = n_err + 1;
  if (synch_ok === 1'b1) n_syn = n_syn + 1;
  if (rx_valid === 1'b1) last_rx = rx_data;
end
task check(input [95:0] nm, input [31:0] seen, input [31:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("wrong value %0s expected %h seen %h", nm, exp, seen);
    end
  end
endtask
task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
endtask
task rdr(input [7:0] a);
  begin
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  end
endtask
task send_tx(input a, input [7:0] d);
  integer k;
  begin
    k = 0;
    while (tx_busy !== 1'b0 && k < 9000)
    begin
      @(posedge clk);
      k = k + 1;
    end
    @(posedge clk);
    tx_data <= d;
    ack_req <= a;
    tx_req <= ~a;
    @(posedge clk);
    ack_req <= 1'b0;
    tx_req <= 1'b0;
  end
endtask
task finish_test;
  begin
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
endtask
initial
begin
  repeat (90000) @(posedge clk);
  err_count = err_count + 1;
  finish_test;
end
initial
begin
  // Row: expect error, parity disable, bad parity, data byte
  rows[0] = 11'h0A5;
  rows[1] = 11'h000;
  rows[2] = 11'h0FF;
  rows[3] = 11'h53C;
  rows[4] = 11'h33C;
  rows[5] = 11'h281;
  repeat (6) @(posedge clk);
  rst_n <= 1'b1;
  rdr(`OWD_CTRL_OFS);
  check("ctrl rst", rd, 32'h6);
  rdr(`OWD_BAUD_OFS);
  check("baud rst", rd, 32'hFFFF);
  host.send_frame(`OWD_SYNCH_BYTE, 1'b0, 1'b0, BT);
  check("synch", n_syn, 1);
  rdr(`OWD_BAUD_OFS);
  check("baud", rd >= 158 && rd <= 162, 1);
  $display("test synch done");
  for (i = 0; i < 6; i = i + 1)
  begin
    wr(`OWD_CTRL_OFS, {29'h0, 2'h3, rows[i][9]});
    n_ok = 0;
    n_err = 0;
    host.send_frame(rows[i][7:0], rows[i][8], 1'b0, BT);
    check("rx err", n_err, rows[i][10]);
    check("rx ok", n_ok, !rows[i][10]);
    if (!rows[i][10]) check("rx data", last_rx, rows[i][7:0]);
  end
  $display("test rows done");
  rdr(`OWD_STS_OFS);
  check("sts perr", rd, 32'h3);
  wr(`OWD_STS_OFS, 32'h2);
  rdr(`OWD_STS_OFS);
  check("sts w1c", rd, 32'h1);
  wr(`OWD_CTRL_OFS, 32'h6);
  n_err = 0;
  host.send_frame(8'h12, 1'b0, 1'b1, BT);
  rdr(`OWD_STS_OFS);
  check("stop err", {n_err[3:0], rd[3:0]}, 8'h15);
  wr(`OWD_STS_OFS, 32'h4);
  @(posedge clk);
  synch_expect <= 1'b1;
  @(posedge clk);
  synch_expect <= 1'b0;
  host.send_frame(`OWD_SYNCH_BYTE, 1'b0, 1'b0, BT);
  check("resynch", n_syn, 2);
  $display("test errors done");
  send_tx(1'b1, 8'h00);
  host.recv_frame(BT, fr);
  check("ack", fr, {2'h3, ^`OWD_ACK_BYTE, `OWD_ACK_BYTE, 1'b0});
  send_tx(1'b0, 8'hC3);
  host.recv_frame(BT, fr);
  check("tx", fr, {2'h3, ^8'hC3, 8'hC3, 1'b0});
  rdr(8'h0C);
  check("unmapped", rd, 32'h0);
  wr(`OWD_BAUD_OFS, 32'h1234);
  rdr(`OWD_BAUD_OFS);
  check("baud ro", rd >= 158 && rd <= 162, 1);
  $display("test send done");
  wr(`OWD_CTRL_OFS, 32'h2);
  rdr(`OWD_CTRL_OFS);
  check("div 16", rd, 32'h2);
  wr(`OWD_CTRL_OFS, 32'h0);
  rdr(`OWD_CTRL_OFS);
  check("div rsvd", rd, 32'h2);
  // Break lands in the middle of a send of released bits
  send_tx(1'b0, 8'hFF);
  repeat (80) @(posedge clk);
  host.send_break(2600);
  host.send_break(2600);
  rdr(`OWD_STS_OFS);
  check("contention", rd[3], 1'b1);
  check("tx abort", tx_busy, 1'b0);
  rdr(`OWD_CTRL_OFS);
  check("div break", rd, 32'h6);
  $display("test break done");
  rst_n <= 1'b0;
  repeat (6) @(posedge clk);
  rst_n <= 1'b1;
  rdr(`OWD_STS_OFS);
  check("sts rerst", rd, 32'h0);
  check("en rerst", port_enabled, 1'b0);
  $display("test reset done");
  finish_test;
end
endmodule
